//--- fpc_codec.sv
`timescale 1ns/1ps

// ==========================================================
// transmit nibble buffer
module fpc_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // fill side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // drain side
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : ptr_inc

    assign in_ready_o  = (cnt_r != (AW + 1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rd_ptr_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    a_fifo_no_overfill : assert property (@(posedge clk_i) disable iff (rst_i)
        (cnt_r == (AW + 1)'(DEPTH)) |=> (cnt_r == (AW + 1)'(DEPTH)) || $past(pop))
        else $error("fifo count rose past full");

endmodule : fpc_fifo

// ==========================================================
// 100 Mb/s coding path
module fpc_codec (
    // clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_i,
    // mac transmit side
    input  wire logic                 tx_valid_i,
    input  fpc_pkg::fpc_tx_word_t     tx_word_i,
    output logic                      tx_ready_o,
    input  wire logic                 bypass_i,
    // mac receive side
    output fpc_pkg::fpc_rx_nib_t      rx_nib_o,
    output logic                      rx_stb_o,
    // line side
    input  wire logic                 line_clk_i,
    output logic                      mlt_pos_o,
    output logic                      mlt_neg_o,
    input  wire logic                 rx_pos_i,
    input  wire logic                 rx_neg_i
);
    import fpc_pkg::*;

    // ==========================================================
    // input synchronisers
    logic [1:0] lclk_sync_r;
    logic [1:0] pos_sync_r;
    logic [1:0] neg_sync_r;
    logic       lclk_prev_r;
    logic       tick;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lclk_sync_r <= 2'h0;
            pos_sync_r  <= 2'h0;
            neg_sync_r  <= 2'h0;
            lclk_prev_r <= 1'b0;
        end else begin
            lclk_sync_r <= {lclk_sync_r[0], line_clk_i};
            pos_sync_r  <= {pos_sync_r[0], rx_pos_i};
            neg_sync_r  <= {neg_sync_r[0], rx_neg_i};
            lclk_prev_r <= lclk_sync_r[1];
        end
    end

    assign tick = lclk_sync_r[1] && !lclk_prev_r;

    // ==========================================================
    // transmit group timing and buffer
    logic [2:0]    bit_cnt_r;
    logic          tx_load;
    fpc_tx_word_t  head;
    logic          head_valid;
    logic          pop_sel;
    logic          fifo_pop;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt_r <= 3'h0;
        end else if (tick) begin
            bit_cnt_r <= (bit_cnt_r == GRP_LAST_BIT) ? 3'h0 : bit_cnt_r + 3'h1;
        end
    end

    assign tx_load  = tick && (bit_cnt_r == GRP_LAST_BIT);
    assign fifo_pop = tx_load && pop_sel;

    // back-pressure reaches the mac through tx_ready_o
    fpc_fifo #(
        .WIDTH ($bits(fpc_tx_word_t)),
        .DEPTH (TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i       (ref_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (tx_valid_i),
        .in_data_i   (tx_word_i),
        .in_ready_o  (tx_ready_o),
        .out_valid_o (head_valid),
        .out_data_o  (head),
        .out_ready_i (fifo_pop)
    );

    // ==========================================================
    // transmit encoder
    fpc_tx_state_t tx_state_r;
    fpc_tx_state_t tx_state_nxt;
    logic [4:0]    tx_grp_nxt;
    logic          tx_start;

    assign tx_start = head_valid && head.en && !bypass_i;

    always_comb begin
        tx_state_nxt = tx_state_r;
        tx_grp_nxt   = CG_IDLE;
        pop_sel      = 1'b0;
        unique case (tx_state_r)
            TX_IDLE: begin
                pop_sel = head_valid;
                if (bypass_i) begin
                    tx_grp_nxt = head_valid ? {head.er, head.d} : CG_IDLE;
                end else if (tx_start) begin
                    tx_grp_nxt   = CG_J;
                    tx_state_nxt = TX_K;
                end else begin
                    tx_grp_nxt = CG_IDLE;
                end
            end
            TX_K: begin
                pop_sel      = head_valid;
                tx_grp_nxt   = CG_K;
                tx_state_nxt = TX_DATA;
            end
            TX_DATA: begin
                pop_sel = head_valid;
                if (head_valid && head.en) begin
                    tx_grp_nxt = head.er ? CG_H : fpc_enc(head.d);
                end else begin
                    tx_grp_nxt   = CG_T;
                    tx_state_nxt = TX_R;
                end
            end
            TX_R: begin
                tx_grp_nxt   = CG_R;
                tx_state_nxt = TX_IDLE;
            end
        endcase
    end

    // one group taken per nibble slot
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_state_r <= TX_IDLE;
        end else if (tx_load) begin
            tx_state_r <= tx_state_nxt;
        end
    end

    // ==========================================================
    // serializer, scrambler, nrzi, mlt-3
    logic [4:0]        tx_shift_r;
    logic [LFSR_W-1:0] tx_lfsr_r;
    logic              tx_scr_bit;
    logic              tx_nrzi_r;
    logic              tx_nrzi_nxt;
    logic [1:0]        mlt_phase_r;
    logic [1:0]        mlt_phase_nxt;
    logic              mlt_pos_r;
    logic              mlt_neg_r;

    // key XOR onto each code bit
    assign tx_scr_bit  = tx_shift_r[4] ^ fpc_lfsr_key(tx_lfsr_r);
    assign tx_nrzi_nxt = tx_nrzi_r ^ tx_scr_bit;
    // each transition advances the three-level cycle
    assign mlt_phase_nxt = mlt_phase_r + {1'b0, tx_nrzi_nxt ^ tx_nrzi_r};

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_shift_r <= CG_IDLE;
        end else if (tx_load) begin
            tx_shift_r <= tx_grp_nxt;
        end else if (tick) begin
            tx_shift_r <= {tx_shift_r[3:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_lfsr_r   <= LFSR_SEED;
            tx_nrzi_r   <= 1'b0;
            mlt_phase_r <= 2'h0;
            mlt_pos_r   <= 1'b0;
            mlt_neg_r   <= 1'b0;
        end else if (tick) begin
            tx_lfsr_r   <= fpc_lfsr_next(tx_lfsr_r);
            tx_nrzi_r   <= tx_nrzi_nxt;
            mlt_phase_r <= mlt_phase_nxt;
            mlt_pos_r   <= (mlt_phase_nxt == MLT_PLUS);
            mlt_neg_r   <= (mlt_phase_nxt == MLT_MINUS);
        end
    end

    assign mlt_pos_o = mlt_pos_r;
    assign mlt_neg_o = mlt_neg_r;

    // ==========================================================
    // receive line decode
    logic [1:0]        rx_lvl_r;
    logic              rx_nrzi_r;
    logic              rx_nrzi_prev_r;
    logic              rx_bit_vld_r;
    logic              rx_nrz;
    logic [LFSR_W-1:0] rx_lfsr_r;
    logic [5:0]        rx_lock_cnt_r;
    logic              rx_locked;
    logic              rx_plain;
    logic              rx_bit_ok;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_lvl_r       <= 2'h0;
            rx_nrzi_r      <= 1'b0;
            rx_nrzi_prev_r <= 1'b0;
            rx_bit_vld_r   <= 1'b0;
        end else begin
            rx_bit_vld_r <= tick;
            if (tick) begin
                // a level change is an nrzi transition
                rx_lvl_r       <= {pos_sync_r[1], neg_sync_r[1]};
                rx_nrzi_prev_r <= rx_nrzi_r;
                rx_nrzi_r      <= rx_nrzi_r ^ (rx_lvl_r != {pos_sync_r[1], neg_sync_r[1]});
            end
        end
    end

    assign rx_nrz    = rx_nrzi_r ^ rx_nrzi_prev_r;
    assign rx_locked = (rx_lock_cnt_r == DESCR_LOCK_BITS);
    assign rx_plain  = rx_nrz ^ fpc_lfsr_key(rx_lfsr_r);
    assign rx_bit_ok = rx_bit_vld_r && rx_locked;

    // unlocked, the line is assumed idle so each bit reveals the key
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_lfsr_r     <= LFSR_SEED;
            rx_lock_cnt_r <= 6'h00;
        end else if (rx_bit_vld_r) begin
            if (rx_locked) begin
                rx_lfsr_r <= fpc_lfsr_next(rx_lfsr_r);
            end else begin
                rx_lfsr_r     <= {rx_lfsr_r[LFSR_W-2:0], ~rx_nrz};
                rx_lock_cnt_r <= rx_lock_cnt_r + 6'h01;
            end
        end
    end

    // ==========================================================
    // receive alignment and decode
    logic [9:0]    rx_win_r;
    logic [9:0]    rx_win_nxt;
    logic [2:0]    rx_cnt_r;
    fpc_rx_state_t rx_state_r;
    logic          rx_jk_hit;
    logic          rx_grp_end;
    logic [4:0]    rx_grp;
    logic [4:0]    rx_dec;
    fpc_rx_nib_t   rx_nib_r;
    logic          rx_stb_r;
    logic          rx_pend_r;

    assign rx_win_nxt = {rx_win_r[8:0], rx_plain};
    assign rx_grp     = rx_win_nxt[4:0];
    assign rx_dec     = fpc_dec(rx_grp);
    assign rx_jk_hit  = rx_bit_ok && (rx_state_r == RX_HUNT) && (rx_win_nxt == {CG_J, CG_K});
    assign rx_grp_end = rx_bit_ok && (rx_state_r != RX_HUNT) && (rx_cnt_r == GRP_LAST_BIT);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_win_r <= 10'h000;
            rx_cnt_r <= 3'h0;
        end else if (rx_bit_ok) begin
            rx_win_r <= rx_win_nxt;
            rx_cnt_r <= (rx_jk_hit || rx_grp_end) ? 3'h0 : rx_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_state_r <= RX_HUNT;
            rx_nib_r   <= '0;
            rx_stb_r   <= 1'b0;
            rx_pend_r  <= 1'b0;
        end else begin
            rx_stb_r  <= 1'b0;
            rx_pend_r <= 1'b0;
            if (rx_jk_hit) begin
                rx_state_r <= RX_FRAME;
                rx_nib_r   <= '{dv: 1'b1, er: 1'b0, d: PREAMBLE_NIB};
                rx_stb_r   <= 1'b1;
                rx_pend_r  <= 1'b1;
            end else if (rx_pend_r) begin
                rx_nib_r <= '{dv: 1'b1, er: 1'b0, d: PREAMBLE_NIB};
                rx_stb_r <= 1'b1;
            end else if (rx_grp_end) begin
                unique case (rx_state_r)
                    RX_FRAME: begin
                        if (rx_grp == CG_T) begin
                            rx_state_r <= RX_SKIP_R;
                            rx_nib_r   <= '0;
                        end else if (rx_grp == CG_IDLE) begin
                            rx_state_r <= RX_HUNT;
                            rx_nib_r   <= '0;
                        end else begin
                            rx_nib_r <= '{dv: 1'b1, er: !rx_dec[4], d: rx_dec[3:0]};
                            rx_stb_r <= 1'b1;
                        end
                    end
                    default: begin
                        rx_state_r <= RX_HUNT;
                    end
                endcase
            end
        end
    end

    assign rx_nib_o = rx_nib_r;
    assign rx_stb_o = rx_stb_r;

    // ==========================================================
    // checks
    // J then K
    a_tx_j_k : assert property (@(posedge ref_clk_i) disable iff (rst_i)
        tx_load && tx_state_r == TX_IDLE && tx_start |=> tx_shift_r == CG_J && tx_state_r == TX_K)
        else $error("frame start did not send J then K");

    a_tx_t_r : assert property (@(posedge ref_clk_i) disable iff (rst_i)
        tx_load && tx_state_r == TX_DATA && !(head_valid && head.en)
        |=> tx_shift_r == CG_T && tx_state_r == TX_R)
        else $error("frame end did not send T then R");

    a_tx_idle_fill : assert property (@(posedge ref_clk_i) disable iff (rst_i)
        tx_load && tx_state_r == TX_IDLE && !bypass_i && !tx_start |=> tx_shift_r == CG_IDLE)
        else $error("idle group missing between frames");

    a_tx_err_grp : assert property (@(posedge ref_clk_i) disable iff (rst_i)
        tx_load && tx_state_r == TX_DATA && head_valid && head.en && head.er
        |=> tx_shift_r == CG_H)
        else $error("transmit error not sent as error group");

    a_nrzi_toggle : assert property (@(posedge ref_clk_i) disable iff (rst_i)
        tick && tx_shift_r[4] != fpc_lfsr_key(tx_lfsr_r) |=> tx_nrzi_r != $past(tx_nrzi_r))
        else $error("nrzi did not toggle on a one");

    a_mlt_exclusive : assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !(mlt_pos_o && mlt_neg_o))
        else $error("both mlt-3 streams driven");

    a_rx_preamble : assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rx_jk_hit |=> (rx_stb_o && rx_nib_o.dv && rx_nib_o.d == PREAMBLE_NIB) [*2])
        else $error("J/K not replaced by two preamble nibbles");

    a_rx_no_tr : assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rx_grp_end && rx_state_r == RX_FRAME && rx_grp == CG_T && !rx_pend_r
        |=> !rx_stb_o && !rx_nib_o.dv)
        else $error("end delimiter passed to the mac");

    a_rx_err_dv : assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rx_stb_o && rx_nib_o.er |-> rx_nib_o.dv && rx_nib_o.d == 4'h0)
        else $error("receive error outside a frame");

endmodule : fpc_codec

//--- fpc_codec_bench.sv
`timescale 1ns/1ps

// ==========================================================
// codec bench, line output looped back to line input
module fpc_codec_bench;
    import fpc_pkg::*;

    logic         ref_clk;
    logic         rst;
    logic         line_clk;
    logic         bypass;
    logic         tx_valid;
    fpc_tx_word_t tx_word;
    logic         tx_ready;
    fpc_rx_nib_t  rx_nib;
    logic         rx_stb;
    logic         mlt_pos;
    logic         mlt_neg;
    int           failures;
    int           compares;
    logic [5:0]   rx_q [$];
    logic         saw_full;
    logic [1:0]   prev_lvl;
    logic [1:0]   last_nz;

    fpc_codec u_fpc_codec (
        .ref_clk_i (ref_clk),   .rst_i     (rst),      .tx_valid_i (tx_valid),
        .tx_word_i (tx_word),   .tx_ready_o(tx_ready), .bypass_i   (bypass),
        .rx_nib_o  (rx_nib),    .rx_stb_o  (rx_stb),   .line_clk_i (line_clk),
        .mlt_pos_o (mlt_pos),   .mlt_neg_o (mlt_neg),  .rx_pos_i   (mlt_pos),
        .rx_neg_i  (mlt_neg)
    );

    fpc_mac_model u_fpc_mac_model (
        .clk_i(ref_clk), .tx_valid_o(tx_valid), .tx_word_o(tx_word), .tx_ready_i(tx_ready)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // line clock free running, phase unrelated to ref_clk
    initial begin
        line_clk = 1'b0;
        #37;
        forever #80 line_clk = ~line_clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic conclude();
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // ==========================================================
    // monitors, mid-cycle so registered outputs have settled
    always @(negedge ref_clk) begin
        if (rx_stb === 1'b1) begin
            rx_q.push_back(rx_nib);
        end
        if (tx_ready === 1'b0) begin
            saw_full = 1'b1;
        end
        if (rst === 1'b0 && {mlt_neg, mlt_pos} !== prev_lvl && {mlt_neg, mlt_pos} !== 2'h0) begin
            check(prev_lvl, 2'h0);
            check({mlt_neg, mlt_pos}, last_nz ^ 2'h3);
            last_nz = {mlt_neg, mlt_pos};
        end
        prev_lvl = {mlt_neg, mlt_pos};
    end

    // pushes a frame, waits for receive to finish, compares nibbles
    task automatic run_frame(input logic [5:0] words [$], input logic [5:0] exp [$]);
        int n;
        foreach (words[i]) begin
            u_fpc_mac_model.push(words[i]);
        end
        u_fpc_mac_model.release_bus();
        n = 0;
        while (!(rx_q.size() >= exp.size() && rx_nib.dv === 1'b0) && n < 6000) begin
            @(posedge ref_clk);
            n++;
        end
        check(8'(n >= 6000), 8'h00);
        repeat (400) @(posedge ref_clk);
        check(8'(rx_q.size()), 8'(exp.size()));
        check(rx_nib.dv, 1'b0);
        foreach (exp[i]) begin
            check(rx_q[i], exp[i]);
        end
        rx_q.delete();
    endtask : run_frame

    task automatic test_data_frame();
        logic [5:0] w [$];
        w = '{6'h25, 6'h25, 6'h25, 6'h25};
        for (int i = 0; i < 16; i++) begin
            w.push_back(6'h20 + 6'(i));
        end
        saw_full = 1'b0;
        run_frame(w, w);
        check(saw_full, 1'b1);
        check(tx_ready, 1'b1);
    endtask : test_data_frame

    task automatic test_error_frame();
        run_frame('{6'h25, 6'h25, 6'h25, 6'h25, 6'h2A, 6'h3B, 6'h2C},
                  '{6'h25, 6'h25, 6'h25, 6'h25, 6'h2A, 6'h30, 6'h2C});
    endtask : test_error_frame

    task automatic test_bypass_frame();
        @(negedge ref_clk);
        bypass = 1'b1;
        run_frame('{6'h38, 6'h31, 6'h29, 6'h34, 6'h2D, 6'h27},
                  '{6'h25, 6'h25, 6'h21, 6'h22});
        @(negedge ref_clk);
        bypass = 1'b0;
    endtask : test_bypass_frame

    initial begin
        failures = 0;
        compares = 0;
        rst      = 1'b1;
        bypass   = 1'b0;
        saw_full = 1'b0;
        prev_lvl = 2'h0;
        last_nz  = 2'h2;
        repeat (5) @(negedge ref_clk);
        check({tx_ready, rx_stb, mlt_pos, mlt_neg}, 4'h8);
        rst = 1'b0;
        // idle line lets the receive descrambler lock
        repeat (1000) @(posedge ref_clk);
        test_data_frame();
        test_error_frame();
        test_bypass_frame();
        conclude();
    end

    initial begin
        #300000;
        failures++;
        conclude();
    end

endmodule : fpc_codec_bench

//--- fpc_mac_model.sv
`timescale 1ns/1ps

// ==========================================================
// mac side of the transmit stream
module fpc_mac_model (
    // clock
    input  wire logic             clk_i,
    // stream toward the codec
    output logic                  tx_valid_o,
    output fpc_pkg::fpc_tx_word_t tx_word_o,
    input  wire logic             tx_ready_i
);
    import fpc_pkg::*;

    initial begin
        tx_valid_o = 1'b0;
        tx_word_o  = '0;
    end

    task automatic push(input fpc_tx_word_t w);
        @(negedge clk_i);
        tx_valid_o = 1'b1;
        tx_word_o  = w;
        // ready only moves at rising edges, so the falling edge shows what the next edge uses
        while (tx_ready_i !== 1'b1) begin
            @(negedge clk_i);
        end
        @(posedge clk_i);
    endtask : push

    // released lines never keep the stale word
    task automatic release_bus();
        @(negedge clk_i);
        tx_valid_o = 1'b0;
        tx_word_o  = ~tx_word_o;
    endtask : release_bus

endmodule : fpc_mac_model

//--- fpc_pkg.sv
// Summary of operation
// - each transmit data nibble maps to its fixed 5-bit code group
// - first two preamble nibbles of a frame are sent as J then K
// - later preamble and data nibbles become code groups, in order, gapless
// - deassertion of transmit enable appends T then R
// - idle groups are sent after R and whenever no frame is active; the code sends J straight after R when the next frame is already waiting
// - bypass input sends raw five bits without 4B5B conversion
// - key stream is XORed onto the code group bits before transmission
// - code groups are serialized and each bit is scrambled before the NRZI stage
// - serial scrambled bits are NRZI encoded before MLT-3 conversion
// - two drive streams carry alternating one events, forming MLT-3
// - receive path turns serial line bits into nibbles for the MAC
// - three-level receive input is turned back into a two-level NRZI stream
// - receive bit timing is recovered from the line clock with the data
// - NRZI receive stream is decoded to NRZ bits
// - NRZ bits are gathered into a parallel window
// - descrambler removes the key stream before alignment
// - J/K detection fixes the group boundary for the rest of the frame
// - aligned groups are decoded to nibbles by reverse table lookup
// - J/K is stripped and replaced by two preamble nibbles
// - T/R ending a frame is never passed on as nibbles
// - each nibble offered with transmit enable is accepted for encoding
// - transmit error in a frame sends an error group instead of data
// - receive valid rises by the start delimiter and falls before T/R
// - symbol bit slots are tied five per nibble period
package fpc_pkg;

    localparam int GRP_W = 5;
    localparam int NIB_W = 4;
    localparam int LFSR_W = 11;
    localparam int LFSR_TAP_A = 10;
    localparam int LFSR_TAP_B = 8;
    localparam logic [LFSR_W-1:0] LFSR_SEED = 11'h7FF;
    localparam logic [5:0] DESCR_LOCK_BITS = 6'h20;
    localparam logic [2:0] GRP_LAST_BIT = 3'h4;
    localparam int TX_FIFO_DEPTH = 8;

    localparam logic [4:0] CG_IDLE = 5'h1F;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0D;
    localparam logic [4:0] CG_R = 5'h07;
    localparam logic [4:0] CG_H = 5'h04;
    localparam logic [3:0] PREAMBLE_NIB = 4'h5;
    localparam logic [1:0] MLT_PLUS = 2'h1;
    localparam logic [1:0] MLT_MINUS = 2'h3;

    localparam logic [4:0] ENC_TABLE [16] = '{
        5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D
    };

    typedef struct packed {
        logic       en;
        logic       er;
        logic [3:0] d;
    } fpc_tx_word_t;

    typedef struct packed {
        logic       dv;
        logic       er;
        logic [3:0] d;
    } fpc_rx_nib_t;

    typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fpc_tx_state_t;
    typedef enum logic [1:0] {RX_HUNT, RX_FRAME, RX_SKIP_R} fpc_rx_state_t;

    function automatic logic [4:0] fpc_enc(input logic [3:0] nib);
        return ENC_TABLE[nib];
    endfunction : fpc_enc

    // returns {hit, nibble}; a miss is an invalid or error group
    function automatic logic [4:0] fpc_dec(input logic [4:0] grp);
        logic [4:0] res;
        res = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (ENC_TABLE[i] == grp) begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction : fpc_dec

    function automatic logic fpc_lfsr_key(input logic [LFSR_W-1:0] s);
        return s[LFSR_TAP_A] ^ s[LFSR_TAP_B];
    endfunction : fpc_lfsr_key

    function automatic logic [LFSR_W-1:0] fpc_lfsr_next(input logic [LFSR_W-1:0] s);
        return {s[LFSR_W-2:0], fpc_lfsr_key(s)};
    endfunction : fpc_lfsr_next

endpackage : fpc_pkg
